// [atx_map.vh]
// constants for the arinc 429 word transmitter
`ifndef ATX_MAP_VH
`define ATX_MAP_VH
// ************************************************************
// opcodes
// ************************************************************
`define ATX_OP_DIV 8'h07
`define ATX_OP_LOAD 8'h0E
`define ATX_OP_CTRL 8'h10
`define ATX_OP_CLEAR 8'h11
`define ATX_OP_SEND 8'h12
// ************************************************************
// control register fields, control and divider reset values
// ************************************************************
`define ATX_CR_DIVSEL 1
`define ATX_CR_PAREN 3
`define ATX_CR_PARSEL 9
`define ATX_CR_RATE 10
`define ATX_CR_ORDER 11
`define ATX_CR_DRVOFF 12
`define ATX_CR_AUTO 13
`define ATX_CR_FLAGSEL 14
`define ATX_CR_RESET 16'h0000
`define ATX_DIV_RESET 8'h01
// ************************************************************
// timing counts in reference ticks, and the fifo half-full level in words
// ************************************************************
`define ATX_HALF_FAST 8'h05
`define ATX_HALF_SLOW 8'h28
`define ATX_GAP_FAST 9'h028
`define ATX_GAP_SLOW 9'h140
`define ATX_HALF_LEVEL 16
`endif

// [atx_transmitter.v]
// arinc 429 word transmitter: fifo, framer, reference divider, line states
`timescale 1ns/1ps
`include "atx_map.vh"
module atx_transmitter #(
	parameter DEPTH = 32,
	parameter AW = 5
)(
	input wire clk,
	input wire resetn,
	input wire master_reset_pin,
	input wire aclk_in,
	input wire cmd_valid,
	input wire [7:0] cmd_opcode,
	input wire [31:0] cmd_data,
	input wire cs_rise,
	output reg line_out_a,
	output reg line_out_b,
	output reg fifo_flag_pin,
	output reg fifo_empty_flag,
	output reg fifo_half_flag,
	output reg fifo_full_flag,
	output reg [15:0] ctrl_q
);
	// ************************************************************
	// helpers
	// ************************************************************
	// spi order to arinc order; arinc bit n sits at index n-1
	function [31:0] map_word;
		input [31:0] w;
		input keep;
		integer i;
		begin
			map_word = w;
			if (!keep)
				for (i = 0; i < 8; i = i + 1)
					map_word[i] = w[7 - i];
		end
	endfunction
	function [31:0] add_parity;
		input [31:0] w;
		input en;
		input even;
		begin
			add_parity = w;
			if (en)
				add_parity[31] = ~(^w[30:0]) ^ even;
		end
	endfunction
	// ************************************************************
	// pin synchronisers: reset pin and reference clock
	// ************************************************************
	reg [2:0] mr_q;
	reg [2:0] ak_q;
	wire mr_on = mr_q[1] & mr_q[2];
	wire ak_rise = ak_q[1] & ~ak_q[2];
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			mr_q <= 3'h0;
			ak_q <= 3'h0;
		end
		else
		begin
			mr_q <= {mr_q[1:0], master_reset_pin};
			ak_q <= {ak_q[1:0], aclk_in};
		end
	end
	// ************************************************************
	// control and divider registers, untouched by master reset
	// ************************************************************
	reg [7:0] div_q;
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			ctrl_q <= `ATX_CR_RESET;
			div_q <= `ATX_DIV_RESET;
		end
		else if (cmd_valid)
		begin
			if (cmd_opcode == `ATX_OP_CTRL)
				ctrl_q <= cmd_data[15:0];
			if (cmd_opcode == `ATX_OP_DIV)
				div_q <= cmd_data[7:0];
		end
	end
	// ************************************************************
	// 1 mhz tick from the reference edge, optionally divided
	// ************************************************************
	reg [7:0] dcnt_q;
	reg tick_q;
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			dcnt_q <= 8'h00;
			tick_q <= 1'b0;
		end
		else
		begin
			tick_q <= 1'b0;
			if (ak_rise)
			begin
				if (!ctrl_q[`ATX_CR_DIVSEL])
					tick_q <= 1'b1;
				else if (dcnt_q + 8'h01 >= div_q)
				begin
					dcnt_q <= 8'h00;
					tick_q <= 1'b1;
				end
				else
					dcnt_q <= dcnt_q + 8'h01;
			end
		end
	end
	// ************************************************************
	// transmit fifo
	// ************************************************************
	reg [31:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_q;
	reg [AW-1:0] rd_q;
	reg [AW:0] cnt_q;
	wire clear = mr_on | (cmd_valid & (cmd_opcode == `ATX_OP_CLEAR));
	wire full = (cnt_q == DEPTH);
	wire push = cmd_valid & (cmd_opcode == `ATX_OP_LOAD) & ~full;
	reg pop;
	// load lands at the next free slot; clear beats everything
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else if (clear)
		begin
			wr_q <= {AW{1'b0}};
			rd_q <= {AW{1'b0}};
			cnt_q <= {(AW+1){1'b0}};
		end
		else
		begin
			if (push)
				wr_q <= wr_q + 1'b1;
			if (pop)
				rd_q <= rd_q + 1'b1;
			if (push & ~pop)
				cnt_q <= cnt_q + 1'b1;
			else if (pop & ~push)
				cnt_q <= cnt_q - 1'b1;
		end
	end
	always @(posedge clk)
	begin
		if (push)
			mem[wr_q] <= map_word(cmd_data, ctrl_q[`ATX_CR_ORDER]);
	end
	// ************************************************************
	// transmit enable: auto after a load's cs rise, or opcode 0x12 with auto off
	// ************************************************************
	reg run_q;
	reg loaded_q;
	reg busy_q;
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			run_q <= 1'b0;
			loaded_q <= 1'b0;
		end
		else if (mr_on)
		begin
			run_q <= 1'b0;
			loaded_q <= 1'b0;
		end
		else
		begin
			if (push)
				loaded_q <= 1'b1;
			else if (cs_rise)
				loaded_q <= 1'b0;
			if (cs_rise & (loaded_q | push) & ctrl_q[`ATX_CR_AUTO])
				run_q <= 1'b1;
			else if (cmd_valid & (cmd_opcode == `ATX_OP_SEND)
				& ~ctrl_q[`ATX_CR_AUTO])
				run_q <= 1'b1;
			else if (cnt_q == 0 && !busy_q && !push)
				run_q <= 1'b0;
		end
	end
	// ************************************************************
	// framer: 32 bits of data half then null half, then word gap
	// ************************************************************
	localparam ST_IDLE = 2'd0;
	localparam ST_DATA = 2'd1;
	localparam ST_NULL = 2'd2;
	localparam ST_GAP = 2'd3;
	reg [1:0] st_q;
	reg [31:0] sh_q;
	reg [4:0] bit_q;
	reg [8:0] tcnt_q;
	wire slow = ctrl_q[`ATX_CR_RATE];
	wire [8:0] half = slow ? {1'b0, `ATX_HALF_SLOW} : {1'b0, `ATX_HALF_FAST};
	wire [8:0] gap = slow ? `ATX_GAP_SLOW : `ATX_GAP_FAST;
	wire tdone = tick_q & (tcnt_q == 9'h001);
	always @*
		pop = (st_q == ST_IDLE) & run_q & (cnt_q != 0) & ~clear;
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			st_q <= ST_IDLE;
			sh_q <= 32'h00000000;
			bit_q <= 5'h00;
			tcnt_q <= 9'h000;
			busy_q <= 1'b0;
		end
		else if (mr_on)
		begin
			st_q <= ST_IDLE;
			busy_q <= 1'b0;
		end
		else
		begin
			if (tick_q && tcnt_q != 0)
				tcnt_q <= tcnt_q - 9'h001;
			case (st_q)
			ST_IDLE:
				if (pop)
				begin
					// label first: arinc bit 1 leaves first
					sh_q <= add_parity(mem[rd_q], ctrl_q[`ATX_CR_PAREN],
						ctrl_q[`ATX_CR_PARSEL]);
					bit_q <= 5'h00;
					tcnt_q <= half;
					busy_q <= 1'b1;
					st_q <= ST_DATA;
				end
			ST_DATA:
				if (tdone)
				begin
					tcnt_q <= half;
					st_q <= ST_NULL;
				end
			ST_NULL:
				if (tdone)
				begin
					sh_q <= {1'b0, sh_q[31:1]};
					bit_q <= bit_q + 5'h01;
					tcnt_q <= (bit_q == 5'h1F) ? gap : half;
					st_q <= (bit_q == 5'h1F) ? ST_GAP : ST_DATA;
				end
			ST_GAP:
				if (tdone)
				begin
					busy_q <= 1'b0;
					st_q <= ST_IDLE;
				end
			default:
				st_q <= ST_IDLE;
			endcase
		end
	end
	// ************************************************************
	// registered outputs: line states and flags
	// ************************************************************
	always @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			line_out_a <= 1'b0;
			line_out_b <= 1'b0;
			fifo_empty_flag <= 1'b0;
			fifo_half_flag <= 1'b0;
			fifo_full_flag <= 1'b0;
			fifo_flag_pin <= 1'b0;
		end
		else
		begin
			// a=1,b=0 one; a=0,b=1 zero; both low null
			if (st_q == ST_DATA && !ctrl_q[`ATX_CR_DRVOFF] && !mr_on)
			begin
				line_out_a <= sh_q[0];
				line_out_b <= ~sh_q[0];
			end
			else
			begin
				line_out_a <= 1'b0;
				line_out_b <= 1'b0;
			end
			// master reset clears the flags outright
			fifo_empty_flag <= ~mr_on & (cnt_q == 0) & ~busy_q;
			fifo_half_flag <= ~mr_on & (cnt_q >= `ATX_HALF_LEVEL);
			fifo_full_flag <= ~mr_on & full;
			fifo_flag_pin <= ~mr_on & (ctrl_q[`ATX_CR_FLAGSEL] ? full
				: ((cnt_q == 0) & ~busy_q));
		end
	end
endmodule

// [atx_assertions.sv]
// port assertions for the arinc 429 word transmitter
`timescale 1ns/1ps
module atx_assertions(
	input wire clk,
	input wire resetn,
	input wire master_reset_pin,
	input wire cmd_valid,
	input wire [7:0] cmd_opcode,
	input wire [31:0] cmd_data,
	input wire line_out_a,
	input wire line_out_b,
	input wire fifo_flag_pin,
	input wire fifo_empty_flag,
	input wire fifo_half_flag,
	input wire fifo_full_flag,
	input wire [15:0] ctrl_q
);
// ************************************************************
// line, flag and control checks
// ************************************************************
default clocking @(posedge clk); endclocking
default disable iff (!resetn);
// control write strobe
wire wr_ctrl = cmd_valid && cmd_opcode == 8'h10;
a_line_three:
	assert property (!(line_out_a && line_out_b)) else $error("both high");
a_drv_null:
	assert property ($past(ctrl_q[12]) && ctrl_q[12] |-> !line_out_a
		&& !line_out_b) else $error("line driven while disabled");
a_flag_empty:
	assert property ((fifo_empty_flag && !ctrl_q[14]) [*3] |-> fifo_flag_pin)
		else $error("flag pin misses empty");
a_flag_full:
	assert property ((fifo_full_flag && ctrl_q[14]) [*3] |-> fifo_flag_pin)
		else $error("flag pin misses full");
a_half_in_full:
	assert property (fifo_full_flag |-> fifo_half_flag && !fifo_empty_flag)
		else $error("full without half");
a_mr_clear:
	assert property (master_reset_pin [*5] |-> !(fifo_empty_flag
		| fifo_half_flag | fifo_full_flag | fifo_flag_pin | line_out_a
		| line_out_b)) else $error("master reset left state");
a_ctrl_load:
	assert property (wr_ctrl |=> ctrl_q == $past(cmd_data[15:0]))
		else $error("control not loaded");
a_ctrl_keep:
	assert property (!wr_ctrl |=> $stable(ctrl_q)) else $error("ctrl moved");
a_clear_fifo:
	assert property (cmd_valid && cmd_opcode == 8'h11 |-> ##2 !fifo_half_flag
		&& !fifo_full_flag) else $error("clear left words");
endmodule
bind atx_transmitter atx_assertions chk_u (.clk(clk), .resetn(resetn),
	.master_reset_pin(master_reset_pin), .cmd_valid(cmd_valid),
	.cmd_opcode(cmd_opcode), .cmd_data(cmd_data), .line_out_a(line_out_a),
	.line_out_b(line_out_b), .fifo_flag_pin(fifo_flag_pin),
	.fifo_empty_flag(fifo_empty_flag), .fifo_half_flag(fifo_half_flag),
	.fifo_full_flag(fifo_full_flag), .ctrl_q(ctrl_q));

// [atx_rx_model.sv]
// arinc 429 bus receiver and reference clock source
`timescale 1ns/1ps
module atx_rx_model(
	input wire clk,
	input wire line_a,
	input wire line_b,
	output reg aclk_in,
	output reg [31:0] word_q,
	output reg [7:0] count_q,
	output reg [15:0] half_q
);
// ************************************************************
// receiver
// ************************************************************
reg [31:0] sh_q = 32'h0;
reg [5:0] n_q = 6'h00;
reg [15:0] run_q = 16'h0000;
reg act_q = 1'b0;
wire act_d = line_a | line_b;
// start values
initial
begin
	aclk_in = 1'b0;
	word_q = 32'h0;
	count_q = 8'h00;
	half_q = 16'h0000;
end
// reference scaled to 25 MHz to keep runs short; duty stays even
always #20 aclk_in = ~aclk_in;
// one bit per rise out of null; a null longer than 1000 cycles restarts
// the frame, so slow-rate nulls of 400 cycles do not break a word
always @(posedge clk)
begin
	act_q <= act_d;
	run_q <= (act_q != act_d) ? 16'h0001
		: (run_q == 16'hFFFF) ? run_q : run_q + 16'h0001;
	if (act_q && !act_d)
		half_q <= run_q;
	if (!act_q && act_d)
	begin
		sh_q <= {line_a, sh_q[31:1]};
		n_q <= (run_q > 16'h03E8) ? 6'h01 : n_q + 6'h01;
	end
	if (n_q == 6'h20)
	begin
		word_q <= sh_q;
		count_q <= count_q + 8'h01;
		n_q <= 6'h00;
	end
end
endmodule

// [atx_transmitter_tb.sv]
// self-checking bench for the arinc 429 word transmitter
`timescale 1ns/1ps
module atx_transmitter_tb;
reg clk, resetn, mreset, vld, cs;
reg [7:0] op, seen;
reg [31:0] dat;
wire la, lb, pin, emp, hlf, ful, aclk;
wire [15:0] ctrl, rxh;
wire [31:0] rxw;
wire [7:0] rxn;
integer num_errors = 0, samples_checked = 0, i, h;
reg [15:0] cv [0:4];
reg [31:0] dv [0:4];
atx_transmitter dut_u (.clk(clk), .resetn(resetn), .master_reset_pin(mreset),
	.aclk_in(aclk), .cmd_valid(vld), .cmd_opcode(op), .cmd_data(dat),
	.cs_rise(cs), .line_out_a(la), .line_out_b(lb), .fifo_flag_pin(pin),
	.fifo_empty_flag(emp), .fifo_half_flag(hlf), .fifo_full_flag(ful),
	.ctrl_q(ctrl));
atx_rx_model rx_u (.clk(clk), .line_a(la), .line_b(lb), .aclk_in(aclk),
	.word_q(rxw), .count_q(rxn), .half_q(rxh));
// ************************************************************
// access tasks
// ************************************************************
function [31:0] exp_w(input [31:0] d, input [15:0] c);
	integer k;
	begin
		exp_w = d;
		for (k = 0; k < 8; k = k + 1)
			if (!c[11]) exp_w[k] = d[7 - k];
		if (c[3]) exp_w[31] = ^exp_w[30:0] ^ !c[9];
	end
endfunction
task cmd(input [7:0] o, input [31:0] d);
	begin
		@(posedge clk);
		vld <= 1'b1;
		op <= o;
		dat <= d;
		@(posedge clk);
		vld <= 1'b0;
	end
endtask
task pulse_cs;
	begin
		@(posedge clk);
		cs <= 1'b1;
		@(posedge clk);
		cs <= 1'b0;
	end
endtask
task nxt(input integer n);
	begin
		repeat (n) @(posedge clk);
		@(negedge clk);
	end
endtask
// bounded wait for the receiver to finish a word
task wait_word;
	integer k;
	begin
		for (k = 0; k < 30000 && rxn === seen; k = k + 1) @(posedge clk);
		chk(rxn !== seen, 1);
		seen = rxn;
	end
endtask
task chk(input [31:0] g, input [31:0] e);
	begin
		samples_checked = samples_checked + 1;
		if (g !== e)
		begin
			num_errors = num_errors + 1;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
		end
	end
endtask
task wrap_up;
	begin
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	end
endtask
// ************************************************************
// clock, watchdog and tests
// ************************************************************
initial
begin
	clk = 1'b0;
	forever #2 clk = ~clk;
end
// well beyond the expected run, at 100k cycles
initial
begin
	#400000;
	num_errors = num_errors + 1;
	wrap_up;
end
// modes table: odd, even, raw with kept label, divided reference, slow rate
initial
begin
	{resetn, mreset, vld, cs, op, dat, seen} = 0;
	{cv[0], cv[1], cv[2], cv[3]} = {16'h2008, 16'h2208, 16'h2800, 16'h2002};
	{dv[0], dv[1]} = {32'h800000C1, 32'h12345601};
	{dv[2], dv[3]} = {32'hF0F00F81, 32'h00000003};
	cv[4] = 16'h2408;
	dv[4] = 32'h5A5A0F3C;
	repeat (4) @(posedge clk);
	resetn <= 1'b1;
	nxt(1);
	chk({ful, hlf, emp, ctrl}, 32'h10000);
	$display("test reset done");
	cmd(8'h07, 32'h2);
	for (i = 0; i < 5; i = i + 1)
	begin
		// half bit in clk cycles: 10 per reference tick, doubled if divided
		h = (cv[i][10] ? 400 : 50) * (cv[i][1] ? 2 : 1);
		cmd(8'h10, cv[i]);
		cmd(8'h0E, dv[i]);
		pulse_cs;
		wait_word;
		chk(rxw, exp_w(dv[i], cv[i]));
		chk(rxh > h - 6 && rxh < h + 6, 1);
		chk(emp, 0);
		// rest of last bit, its null and the word gap: 10 half bits
		nxt(10 * h + 20);
		chk(emp, 1);
	end
	$display("test modes done");
	cmd(8'h10, 32'h2000);
	cmd(8'h0E, 32'hA5A55A5A);
	cmd(8'h12, 32'h0);
	nxt(900);
	chk(rxn, seen);
	cmd(8'h10, 32'h0);
	pulse_cs;
	nxt(900);
	chk(rxn, seen);
	cmd(8'h12, 32'h0);
	wait_word;
	chk(rxw, exp_w(32'hA5A55A5A, 16'h0));
	$display("test software send done");
	cmd(8'h10, 32'h4000);
	for (i = 0; i < 33; i = i + 1)
	begin
		cmd(8'h0E, i);
		if (i == 14 || i == 15)
		begin
			nxt(2);
			chk(hlf, i == 15);
		end
	end
	nxt(2);
	chk({ful, pin, emp}, 3'b110);
	@(posedge clk);
	mreset <= 1'b1;
	nxt(6);
	chk({ful, hlf, emp, pin}, 0);
	chk(ctrl, 16'h4000);
	@(posedge clk);
	mreset <= 1'b0;
	nxt(4);
	$display("test fill done");
	cmd(8'h10, 32'h0);
	nxt(2);
	chk(hlf, 0);
	for (i = 0; i < 16; i = i + 1)
		cmd(8'h0E, i);
	nxt(2);
	chk({hlf, emp}, 2'b10);
	cmd(8'h11, 32'h0);
	nxt(2);
	chk({hlf, emp, pin}, 3'b011);
	cmd(8'h10, 32'h3000);
	cmd(8'h0E, 32'h1);
	pulse_cs;
	nxt(4000);
	chk(rxn, seen);
	chk(emp, 1);
	$display("test clear and disable done");
	wrap_up;
end
endmodule
